// ==== hw/bound_check_if.sv ====
/*
 * Carrier between one requester (the stack sequencer or the other-address path) and one bound comparator.
 * Assumes both ends share the core clock.
 */
`timescale 1ns/1ps

interface bound_check_if;
    logic        check;
    logic [15:0] addr;
    logic        over;
    logic        under;

    modport requester (
        output check,
        output addr,
        input  over,
        input  under
    );

    modport comparer (
        input  check,
        input  addr,
        output over,
        output under
    );
endinterface

// ==== hw/pc_frame_former.sv ====
/*
 * Forms the two stacked words of a program counter push.
 * Assumes the caller stores low word first, upper word second.
 */
`timescale 1ns/1ps

module pc_frame_former
    import stack_pkg::*;
(
    input  wire logic [PC_W-1:0]   pc,
    input  wire logic [SRL_W-1:0]  status_low_byte,
    input  wire logic              in_exception,
    output logic      [DATA_W-1:0] low_word,
    output logic      [DATA_W-1:0] high_word
);

    // ------------------------------------------------------------------
    // frame words
    // ------------------------------------------------------------------

    // upper word: zero padded on calls, status byte on exceptions
    always_comb begin
        low_word = pc[DATA_W-1:0];
        if (in_exception) begin
            high_word = {status_low_byte, PC_UPPER_PAD,
                         pc[PC_UPPER_MSB:PC_UPPER_LSB]};
        end else begin
            high_word = {{(DATA_W-PC_UPPER_W){1'b0}},
                         pc[PC_UPPER_MSB:PC_UPPER_LSB]};
        end
    end

endmodule

// ==== hw/stack_bound_compare.sv ====
/*
 * Compares one stack-relative address against the limit and the fixed floor.
 * Assumes the limit is word aligned and qualified by limit_valid.
 */
`timescale 1ns/1ps

module stack_bound_compare
    import stack_pkg::*;
(
    bound_check_if.comparer chk,
    input  wire logic [15:0] limit,
    input  wire logic        limit_valid
);

    // ------------------------------------------------------------------
    // compare
    // ------------------------------------------------------------------

    // above the limit only counts once software has set one
    always_comb begin
        chk.over  = chk.check && limit_valid && (chk.addr > limit);
        chk.under = chk.check && (chk.addr < STACK_FLOOR);
    end

endmodule

// ==== hw/stack_pkg.sv ====
/*
 * Constants and types shared by the stack pointer and limit checking logic.
 * Assumes a 16-bit byte-addressed data space and a 23-bit program counter.
 */
package stack_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int DATA_W     = 16;
    localparam int PC_W       = 23;
    localparam int PC_UPPER_W = 7;
    localparam int SRL_W      = 8;

    // ------------------------------------------------------------------
    // addresses and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] STACK_FLOOR      = 16'h0800;
    localparam logic [15:0] SP_RESET         = 16'h0800;
    localparam logic [15:0] WORD_STEP        = 16'h0002;
    localparam logic [15:0] WORD_ALIGN_MASK  = 16'hFFFE;
    localparam logic [15:0] LIMIT_UNSET_READ = 16'h0000;
    localparam logic [15:0] ADDR_RESET       = 16'h0000;
    localparam logic [15:0] DATA_RESET       = 16'h0000;

    // ------------------------------------------------------------------
    // field positions of the stored upper program counter word
    // ------------------------------------------------------------------
    localparam int PC_UPPER_LSB = 16;
    localparam int PC_UPPER_MSB = 22;
    localparam logic PC_UPPER_PAD = 1'b0;

    // ------------------------------------------------------------------
    // stack operations and sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_PUSH   = 2'h0,
        OP_POP    = 2'h1,
        OP_CALL   = 2'h2,
        OP_EXCEPT = 2'h3
    } stack_op_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'h0,
        ST_PC_HIGH = 2'h1
    } seq_state_t;

endpackage

// ==== hw/stack_pointer_limit_check.sv ====
/*
 * Software stack pointer with upward growth, limit and floor checking.
 * Assumes the core presents one stack operation at a time on op_valid,
 * holds it until op_ready, and reports every other address it forms
 * from the pointer on ea_valid in the cycle it is formed.
 */
// Operation
// - working register fifteen doubles as stack pointer
// - pointer always names first free word
// - stack grows toward higher addresses
// - push writes then increments; pop decrements then reads
// - call push zero-extends upper program counter
// - exception push joins status byte to counter
// - limit register untouched by reset
// - limit bit zero forced to zero
// - pointer-based addresses compared against limit
// - push at limit passes, next one traps
// - pointer below floor raises stack error
`timescale 1ns/1ps

module stack_pointer_limit_check
    import stack_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // stack operation request
    input  wire logic              op_valid,
    input  wire logic [1:0]        op_kind,
    input  wire logic [DATA_W-1:0] op_data,
    input  wire logic [PC_W-1:0]   pc_value,
    input  wire logic [SRL_W-1:0]  status_low_byte,
    output logic                   op_ready,
    // ordinary pointer register access
    input  wire logic              sp_wr_en,
    input  wire logic [DATA_W-1:0] sp_wr_data,
    output logic      [DATA_W-1:0] stack_pointer_working_reg,
    // limit register access
    input  wire logic              limit_wr_en,
    input  wire logic [DATA_W-1:0] limit_wr_data,
    output logic      [DATA_W-1:0] stack_limit_reg,
    output logic                   limit_valid,
    // other addresses formed from the pointer
    input  wire logic              ea_valid,
    input  wire logic              ea_read,
    input  wire logic [DATA_W-1:0] effective_address,
    // stack memory access
    output logic                   mem_wr_en,
    output logic                   mem_rd_en,
    output logic      [DATA_W-1:0] mem_addr,
    output logic      [DATA_W-1:0] mem_wdata,
    // stack error trap and misuse flag
    output logic                   stack_error,
    output logic                   stack_overflow,
    output logic                   stack_underflow,
    output logic                   limit_hazard
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    // sequencer
    seq_state_t        state;
    seq_state_t        next_state;
    logic [DATA_W-1:0] sp;
    logic [DATA_W-1:0] next_sp;
    logic [DATA_W-1:0] high_word;
    logic [DATA_W-1:0] next_high_word;
    logic              next_mem_wr_en;
    logic              next_mem_rd_en;
    logic [DATA_W-1:0] next_mem_addr;
    logic [DATA_W-1:0] next_mem_wdata;

    // trap pulses
    logic              next_stack_error;
    logic              next_stack_overflow;
    logic              next_stack_underflow;

    // limit register
    logic [DATA_W-1:0] limit;
    logic [DATA_W-1:0] next_limit;
    logic              next_limit_valid;
    logic              limit_just_written;
    logic              next_limit_just_written;
    logic              next_limit_hazard;
    logic [DATA_W-1:0] next_limit_read;

    // frame words, pointer steps and decoded request
    logic [DATA_W-1:0] frame_low;
    logic [DATA_W-1:0] frame_high;
    logic [DATA_W-1:0] sp_up;
    logic [DATA_W-1:0] sp_down;
    stack_op_t         kind;

    // carriers to the two bound comparators
    bound_check_if acc_chk ();
    bound_check_if ea_chk ();

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // word steps of the pointer and the decoded request;
    // op_ready follows the state alone, so the core sees a
    // refused request in the same cycle and holds it
    always_comb begin
        sp_up    = sp + WORD_STEP;
        sp_down  = sp - WORD_STEP;
        kind     = stack_op_t'(op_kind);
        op_ready = (state == ST_IDLE);
    end

    // both program counter words formed up front
    pc_frame_former u_frame (
        .pc              (pc_value),
        .status_low_byte (status_low_byte),
        .in_exception    (kind == OP_EXCEPT),
        .low_word        (frame_low),
        .high_word       (frame_high)
    );

    // one comparator for stack accesses, one for other pointer addresses
    // so that both can be checked in the same cycle
    stack_bound_compare u_acc_cmp (
        .chk         (acc_chk.comparer),
        .limit       (limit),
        .limit_valid (limit_valid)
    );

    stack_bound_compare u_ea_cmp (
        .chk         (ea_chk.comparer),
        .limit       (limit),
        .limit_valid (limit_valid)
    );

    // other addresses formed from the pointer are checked too;
    // the core raises ea_valid only for pointer-based addresses
    always_comb begin
        ea_chk.check = ea_valid;
        ea_chk.addr  = effective_address;
    end

    // ------------------------------------------------------------------
    // stack sequencer
    // ------------------------------------------------------------------

    // pushes, pops and program counter frames; a frame takes two
    // cycles, low word when taken and upper word the next cycle,
    // with op_ready low in between so no other request slips in
    always_comb begin
        next_state     = state;
        next_sp        = sp;
        next_high_word = high_word;
        next_mem_wr_en = 1'b0;
        next_mem_rd_en = 1'b0;
        next_mem_addr  = mem_addr;
        next_mem_wdata = mem_wdata;
        acc_chk.check  = 1'b0;
        acc_chk.addr   = sp;
        unique case (state)
            ST_IDLE: begin
                if (op_valid) begin
                    unique case (kind)
                        OP_PUSH: begin
                            // store at first free word, then step up
                            acc_chk.check  = 1'b1;
                            next_mem_wr_en = 1'b1;
                            next_mem_addr  = sp;
                            next_mem_wdata = op_data;
                            next_sp        = sp_up;
                        end
                        OP_POP: begin
                            // step down, then read the new address
                            acc_chk.check  = 1'b1;
                            acc_chk.addr   = sp_down;
                            next_mem_rd_en = 1'b1;
                            next_mem_addr  = sp_down;
                            next_sp        = sp_down;
                        end
                        OP_CALL, OP_EXCEPT: begin
                            // low counter word first, upper word next cycle
                            acc_chk.check  = 1'b1;
                            next_mem_wr_en = 1'b1;
                            next_mem_addr  = sp;
                            next_mem_wdata = frame_low;
                            next_high_word = frame_high;
                            next_sp        = sp_up;
                            next_state     = ST_PC_HIGH;
                        end
                    endcase
                end else if (sp_wr_en) begin
                    // ordinary register write, kept word aligned
                    next_sp = sp_wr_data & WORD_ALIGN_MASK;
                end
            end
            ST_PC_HIGH: begin
                acc_chk.check  = 1'b1;
                next_mem_wr_en = 1'b1;
                next_mem_addr  = sp;
                next_mem_wdata = high_word;
                next_sp        = sp_up;
                next_state     = ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state     <= ST_IDLE;
            sp        <= SP_RESET;
            high_word <= DATA_RESET;
            mem_wr_en <= 1'b0;
            mem_rd_en <= 1'b0;
            mem_addr  <= ADDR_RESET;
            mem_wdata <= DATA_RESET;
        end else begin
            state     <= next_state;
            sp        <= next_sp;
            high_word <= next_high_word;
            mem_wr_en <= next_mem_wr_en;
            mem_rd_en <= next_mem_rd_en;
            mem_addr  <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
        end
    end

    assign stack_pointer_working_reg = sp;

    // ------------------------------------------------------------------
    // stack error reporting
    // ------------------------------------------------------------------

    // either comparator raises the trap pulse; a trap never blocks
    // the access, the pointer still moves and the core's exception
    // logic decides what follows
    always_comb begin
        next_stack_overflow  = acc_chk.over | ea_chk.over;
        next_stack_underflow = acc_chk.under | ea_chk.under;
        next_stack_error     = next_stack_overflow | next_stack_underflow;
    end

    // trap pulses, one cycle each
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stack_error     <= 1'b0;
            stack_overflow  <= 1'b0;
            stack_underflow <= 1'b0;
        end else begin
            stack_error     <= next_stack_error;
            stack_overflow  <= next_stack_overflow;
            stack_underflow <= next_stack_underflow;
        end
    end

    // ------------------------------------------------------------------
    // limit register
    // ------------------------------------------------------------------

    // written value is word aligned, so the limit
    // compares like any stack address
    always_comb begin
        next_limit = limit;
        if (limit_wr_en) begin
            next_limit = limit_wr_data & WORD_ALIGN_MASK;
        end
    end

    // no reset here: content is undefined until first written;
    // limit_valid keeps unknowns out of every comparison
    always_ff @(posedge clk) begin
        limit <= next_limit;
    end

    // tracks whether software has set a limit yet; an unset limit
    // reads as zero rather than leaking unknowns, and the misuse
    // flag marks a pointer read right after a limit write
    always_comb begin
        next_limit_valid        = limit_valid | limit_wr_en;
        next_limit_just_written = limit_wr_en;
        next_limit_hazard       = limit_just_written && ea_valid && ea_read;
        next_limit_read         = next_limit_valid ? next_limit : LIMIT_UNSET_READ;
    end

    // validity, misuse flag and visible limit
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            limit_valid        <= 1'b0;
            limit_just_written <= 1'b0;
            limit_hazard       <= 1'b0;
            stack_limit_reg    <= LIMIT_UNSET_READ;
        end else begin
            limit_valid        <= next_limit_valid;
            limit_just_written <= next_limit_just_written;
            limit_hazard       <= next_limit_hazard;
            stack_limit_reg    <= next_limit_read;
        end
    end

endmodule

// ==== test/core_ea_model.sv ====
/*
 * Core address generator: passes pointer-based addresses to the checker.
 * Assumes the bench requests addresses just after a clock edge.
 */
`timescale 1ns/1ps

module core_ea_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        limit_wr_en,
    input  wire logic        req,
    input  wire logic        rd,
    input  wire logic        permit,
    input  wire logic [15:0] addr,
    output logic             ea_valid,
    output logic             ea_read,
    output logic [15:0]      effective_address
);
    logic last_lim;
    logic next_last_lim;

    // remembers a limit write one cycle back
    always_comb begin
        next_last_lim = rst_b ? limit_wr_en : 1'b0;
    end
    always_ff @(posedge clk) begin
        last_lim <= next_last_lim;
    end

    // holds back a pointer read right after a limit write unless told not to
    assign ea_valid = req && !(rd && last_lim && !permit);
    assign ea_read = rd;
    assign effective_address = req ? addr : ~addr;
endmodule

// ==== test/stack_limit_sva.sv ====
/*
 * Assertions on the ports of the stack pointer and limit checker.
 * Assumes one core clock and the synchronous active-low reset rst_b.
 */
`timescale 1ns/1ps

module stack_limit_sva
    import stack_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              op_valid,
    input wire logic [1:0]        op_kind,
    input wire logic [PC_W-1:0]   pc_value,
    input wire logic [SRL_W-1:0]  status_low_byte,
    input wire logic              op_ready,
    input wire logic [DATA_W-1:0] stack_pointer_working_reg,
    input wire logic              limit_wr_en,
    input wire logic [DATA_W-1:0] limit_wr_data,
    input wire logic [DATA_W-1:0] stack_limit_reg,
    input wire logic              limit_valid,
    input wire logic              ea_valid,
    input wire logic [DATA_W-1:0] effective_address,
    input wire logic              mem_wr_en,
    input wire logic              mem_rd_en,
    input wire logic [DATA_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_wdata,
    input wire logic              stack_error,
    input wire logic              stack_overflow,
    input wire logic              stack_underflow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------------
    // stack operations
    // ------------------------------------------------------------------
    wire take = op_valid && op_ready;
    wire [15:0] sp = stack_pointer_working_reg;

    property p_push;
        take && op_kind == 2'h0 |=> mem_wr_en && mem_addr == $past(sp)
            && sp == $past(sp) + WORD_STEP;
    endproperty
    a_push: assert property (p_push) else $error("push access wrong");

    property p_pop;
        take && op_kind == 2'h1 |=> mem_rd_en && mem_addr == sp
            && sp == $past(sp) - WORD_STEP;
    endproperty
    a_pop: assert property (p_pop) else $error("pop access wrong");

    property p_call;
        take && op_kind == 2'h2 |=> !op_ready ##1 mem_wr_en
            && mem_wdata == {9'h000, $past(pc_value[22:16], 2)};
    endproperty
    a_call: assert property (p_call) else $error("call upper word wrong");

    property p_exc;
        take && op_kind == 2'h3 |=> ##1 mem_wr_en && mem_wdata ==
            {$past(status_low_byte, 2), 1'b0, $past(pc_value[22:16], 2)};
    endproperty
    a_exc: assert property (p_exc) else $error("exception upper word wrong");

    // ------------------------------------------------------------------
    // limit and floor checks
    // ------------------------------------------------------------------
    property p_limit;
        limit_wr_en |=> limit_valid
            && stack_limit_reg == ($past(limit_wr_data) & WORD_ALIGN_MASK);
    endproperty
    a_limit: assert property (p_limit) else $error("limit not aligned");

    property p_under;
        ea_valid && effective_address < STACK_FLOOR |=> stack_underflow && stack_error;
    endproperty
    a_under: assert property (p_under) else $error("underflow missed");

    property p_over;
        ea_valid && limit_valid && !limit_wr_en && effective_address > stack_limit_reg
            |=> stack_overflow && stack_error;
    endproperty
    a_over: assert property (p_over) else $error("overflow missed");

    property p_at_limit;
        take && op_kind == 2'h0 && limit_valid && !limit_wr_en && !ea_valid
            && sp == stack_limit_reg && sp >= STACK_FLOOR |=> !stack_error;
    endproperty
    a_at_limit: assert property (p_at_limit) else $error("trap at limit");

    // main scenarios reached
    c_over: cover property (take && op_kind == 2'h0 ##1 stack_overflow);
    c_call: cover property (take && op_kind == 2'h2 ##2 mem_wr_en);
    c_under: cover property (ea_valid ##1 stack_underflow);
endmodule

bind stack_pointer_limit_check stack_limit_sva chk (
    .clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op_kind(op_kind),
    .pc_value(pc_value), .status_low_byte(status_low_byte), .op_ready(op_ready),
    .stack_pointer_working_reg(stack_pointer_working_reg), .limit_wr_en(limit_wr_en),
    .limit_wr_data(limit_wr_data), .stack_limit_reg(stack_limit_reg),
    .limit_valid(limit_valid), .ea_valid(ea_valid), .effective_address(effective_address),
    .mem_wr_en(mem_wr_en), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .stack_error(stack_error), .stack_overflow(stack_overflow),
    .stack_underflow(stack_underflow)
);

// ==== test/tb_stack_pointer_limit_check.sv ====
/*
 * Self-checking bench for the stack pointer and limit checker.
 * Assumes the checker bind file and the core address model are compiled first.
 */
`timescale 1ns/1ps

module tb_stack_pointer_limit_check;
    import stack_pkg::*;
    typedef struct {logic wr; logic err; logic [15:0] addr; logic [15:0] data;} exp_t;

    logic        clk = 0, rst_b = 0, op_valid = 0, sp_wr_en = 0, limit_wr_en = 0;
    logic        ea_req = 0, ea_rd = 0, permit = 0, lim_set = 0;
    logic [1:0]  op_kind = 0;
    logic [15:0] op_data = 0, sp_wr_data = 0, limit_wr_data = 0, ea_addr = 0;
    logic [15:0] sp = SP_RESET, lim = 16'h0000;
    logic [22:0] pc_value = 0;
    logic [7:0]  status_low_byte = 0;
    wire         op_ready, limit_valid, ea_valid, ea_read, mem_wr_en, mem_rd_en;
    wire         stack_error, stack_overflow, stack_underflow, limit_hazard;
    wire [15:0]  stack_pointer_working_reg, stack_limit_reg, effective_address;
    wire [15:0]  mem_addr, mem_wdata;
    int          miscompares = 0, num_checks = 0;
    exp_t        q[$];
    exp_t        e;

    always #20 clk = ~clk;

    stack_pointer_limit_check dut (.clk(clk), .rst_b(rst_b), .op_valid(op_valid),
        .op_kind(op_kind), .op_data(op_data), .pc_value(pc_value),
        .status_low_byte(status_low_byte), .op_ready(op_ready), .sp_wr_en(sp_wr_en),
        .sp_wr_data(sp_wr_data), .stack_pointer_working_reg(stack_pointer_working_reg),
        .limit_wr_en(limit_wr_en), .limit_wr_data(limit_wr_data),
        .stack_limit_reg(stack_limit_reg), .limit_valid(limit_valid), .ea_valid(ea_valid),
        .ea_read(ea_read), .effective_address(effective_address), .mem_wr_en(mem_wr_en),
        .mem_rd_en(mem_rd_en), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .stack_error(stack_error), .stack_overflow(stack_overflow),
        .stack_underflow(stack_underflow), .limit_hazard(limit_hazard));

    core_ea_model core_ea (.clk(clk), .rst_b(rst_b), .limit_wr_en(limit_wr_en),
        .req(ea_req), .rd(ea_rd), .permit(permit), .addr(ea_addr), .ea_valid(ea_valid),
        .ea_read(ea_read), .effective_address(effective_address));

    // ------------------------------------------------------------------
    // compare and expectation helpers
    // ------------------------------------------------------------------
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask

    function automatic logic bad(input logic [15:0] a);
        return a < STACK_FLOOR || (lim_set && a > lim);
    endfunction

    // one stack operation, expectation noted before it is presented
    task automatic op(input logic [1:0] k);
        logic [15:0] hi;
        op_kind = k;
        op_data = 16'($urandom);
        pc_value = 23'($urandom);
        status_low_byte = 8'($urandom);
        hi = (k == 2'h2) ? {9'h000, pc_value[22:16]} : {status_low_byte, 1'b0, pc_value[22:16]};
        if (k == 2'h0) begin
            q.push_back('{1'b1, bad(sp), sp, op_data});
            sp = sp + 16'h0002;
        end else if (k == 2'h1) begin
            sp = sp - 16'h0002;
            q.push_back('{1'b0, bad(sp), sp, 16'h0000});
        end else begin
            q.push_back('{1'b1, bad(sp), sp, pc_value[15:0]});
            q.push_back('{1'b1, bad(sp + 16'h0002), sp + 16'h0002, hi});
            sp = sp + 16'h0004;
        end
        op_valid = 1;
        @(negedge clk);
        while (op_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        #2;
    endtask

    task automatic idle;
        op_valid = 0;
        repeat (3) @(posedge clk);
        #2;
    endtask

    task automatic lw(input logic [15:0] d);
        limit_wr_data = d;
        limit_wr_en = 1;
        @(posedge clk);
        #2;
        limit_wr_en = 0;
        lim = d & WORD_ALIGN_MASK;
        lim_set = 1;
    endtask

    // one pointer-based address; v says whether the core lets it through
    task automatic ea(input logic [15:0] a, input logic rd, input logic v, input logic hz);
        ea_addr = a;
        ea_rd = rd;
        ea_req = 1;
        @(posedge clk);
        #1;
        chk1(stack_error, v && bad(a));
        chk1(stack_underflow, v && a < STACK_FLOOR);
        chk1(limit_hazard, hz);
        #1;
        ea_req = 0;
        @(posedge clk);
        #2;
    endtask

    task automatic end_of_test;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // takes the oldest note whenever a stack access appears
    always @(posedge clk) begin
        #1;
        if (mem_wr_en === 1'b1 || mem_rd_en === 1'b1) begin
            if (q.size() == 0) begin
                miscompares++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, mem_addr, 16'h0000);
            end else begin
                e = q.pop_front();
                chk1(mem_wr_en, e.wr);
                chk16(mem_addr, e.addr);
                if (e.wr) chk16(mem_wdata, e.data);
                chk1(stack_error, e.err);
            end
        end
    end

    initial begin
        #(40 * 3000);
        miscompares++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(23804));
        repeat (8) @(posedge clk);
        #2;
        rst_b = 1;
        chk16(stack_limit_reg, LIMIT_UNSET_READ);
        chk1(limit_valid, 1'b0);
        lw(16'h0811);
        chk16(stack_limit_reg, 16'h0810);
        $display("test limit write done");
        repeat (10) op(2'h0);
        repeat (3) op(2'h1);
        idle();
        chk16(stack_pointer_working_reg, sp);
        $display("test push past limit and pop done");
        op(2'h2);
        op(2'h3);
        idle();
        $display("test call and exception frames done");
        sp_wr_data = 16'h07FD;
        sp_wr_en = 1;
        @(posedge clk);
        #2;
        sp_wr_en = 0;
        sp = 16'h07FC;
        chk16(stack_pointer_working_reg, sp);
        op(2'h1);
        op(2'h0);
        idle();
        $display("test underflow done");
        ea(16'h0700, 1'b0, 1'b1, 1'b0);
        ea(16'h0900, 1'b1, 1'b1, 1'b0);
        ea(16'h0810, 1'b1, 1'b1, 1'b0);
        permit = 1;
        lw(16'h0A00);
        ea(16'h0A02, 1'b1, 1'b1, 1'b1);
        permit = 0;
        lw(16'h0A00);
        ea(16'h0700, 1'b1, 1'b0, 1'b0);
        $display("test address checks done");
        chk16(16'(q.size()), 16'h0000);
        end_of_test();
    end
endmodule
